/* File: include/spc_pkg.sv */
package spc_pkg;

  localparam int NUM_PORTS = 3;

  // per-port register offsets, port 1 first
  localparam logic [7:0] CTRL1_OFF [NUM_PORTS] = '{8'h11, 8'h21, 8'h31};
  localparam logic [7:0] CTRL2_OFF [NUM_PORTS] = '{8'h12, 8'h22, 8'h32};

  // first control register bit positions
  localparam int C1_MIRROR_DEST = 7;
  localparam int C1_RX_MONITOR = 6;
  localparam int C1_TX_MONITOR = 5;
  localparam int C1_DOUBLE_TAG = 4;
  localparam int C1_RESERVED = 3;
  localparam int C1_MEMBER_MSB = 2;

  // second control register bit positions
  localparam int C2_RESERVED = 7;
  localparam int C2_INGRESS_FILTER = 6;
  localparam int C2_DROP_NON_DEFAULT = 5;
  localparam int C2_FORCE_PAUSE = 4;
  localparam int C2_BACKPRESSURE = 3;
  localparam int C2_TX_ENABLE = 2;
  localparam int C2_RX_ENABLE = 1;
  localparam int C2_LEARN_OFF = 0;

  // fixed reset values
  localparam logic [4:0] C1_UPPER_RESET = 5'h00;
  localparam logic [2:0] C2_UPPER_RESET = 3'h0;
  localparam logic [2:0] C2_LOWER_RESET = 3'h6;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // default tag layout
  localparam int TAG_PRIO_MSB = 15;
  localparam int TAG_PRIO_LSB = 13;
  localparam int TAG_CFI = 12;
  localparam int TAG_VID_MSB = 11;

  // strap synchroniser depth and least reset hold
  localparam int STRAP_SYNC_STAGES = 3;
  localparam int RESET_HOLD_CYCLES = 4;

  typedef struct packed {
    logic mirror_dest;
    logic rx_monitor;
    logic tx_monitor;
    logic double_tag;
    logic reserved;
    logic [2:0] member;
  } spc_ctrl1_t;

  typedef struct packed {
    logic reserved;
    logic ingress_filter;
    logic drop_non_default;
    logic force_pause;
    logic backpressure;
    logic tx_enable;
    logic rx_enable;
    logic learn_off;
  } spc_ctrl2_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spc_reg_req_t;

endpackage

/* File: hdl/spc_port_ctrl_regs.sv */
// Contract
// RQ1: two control registers per port at 0x11/0x12, 0x21/0x22, 0x31/0x32, same layout.
// RQ2: first register bit 7 makes the port mirror destination; resets to 0.
// RQ3: bit 6 mirrors every received packet to the mirror destination; resets 0.
// RQ4: bit 5 mirrors every transmitted packet to the mirror destination; resets 0.
// RQ5: bit 4 adds ingress default tag to every packet, tagged or not.
// RQ6: bits 2:0 are egress membership, bit 2 port 3, bit 0 port 1.
// RQ7: forward only to ports inside the source port's membership mask.
// RQ8: own membership bit resets to one, other two from strap pins.
// RQ9: first register bit 3 is a plain reserved bit, reset 0.
// RQ10: second register bit 6 drops packets whose VLAN entry excludes ingress port.
// RQ11: bit 5 drops packets whose VID differs from port default VID.
// RQ12: bit 4 forces flow control on; ports 1 and 2 reset from straps.
// RQ13: port 3 ignores forced flow control; a global bit governs it.
// RQ14: bit 3 enables half-duplex back pressure; resets from shared strap.
// RQ15: bit 2 enables transmission; resets to 1.
// RQ16: bit 1 enables reception; resets to 1.
// RQ17: bit 0 set stops address learning; resets 0, learning on.
// RQ18: second register bit 7 is reserved and reads 0.
// RQ19: port default VID serves lookup and the non-default-VID check.
// RQ20: default tag: priority bits 15:13, CFI bit 12, VID bits 11:0.
// RQ21: writes take effect for packets that start after the write.
// RQ22: strap values are captured during reset and held after release.
`timescale 1ns/1ns

module spc_port_ctrl_regs
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire spc_pkg::spc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // strap pins
  input wire logic strap_p1_member_p3,
  input wire logic strap_p1_member_p2,
  input wire logic strap_p2_member_p3,
  input wire logic strap_p2_member_p1,
  input wire logic strap_p3_member_p2,
  input wire logic strap_p3_member_p1,
  input wire logic strap_p1_force_pause,
  input wire logic strap_p2_force_pause,
  input wire logic strap_backpressure_on,
  // forwarding and ingress checks, index 0 is port 1
  input wire logic [2:0][2:0] fwd_req,
  input wire logic [2:0] pkt_check,
  input wire logic [2:0][11:0] pkt_vid,
  input wire logic [2:0][2:0] vlan_entry_member,
  input wire logic [2:0][15:0] port_default_tag,
  // flow control sources
  input wire logic [2:0] an_pause,
  input wire logic global_pause_p3,
  // control outputs
  output spc_pkg::spc_ctrl1_t [2:0] cfg1,
  output spc_pkg::spc_ctrl2_t [2:0] cfg2,
  output logic [2:0][2:0] fwd_allow,
  output logic [2:0] ingress_drop,
  output logic [2:0] pause_en,
  output logic [2:0] learn_en,
  output logic [2:0][11:0] port_default_vlan_id,
  output logic [2:0][2:0] default_prio,
  output logic [2:0] default_cfi
);
  import spc_pkg::*;

  logic [8:0] strap_pins;
  logic [8:0] strap_s1;
  logic [8:0] strap_s2;
  logic [8:0] strap_s3;
  logic [8:0] strap_stable;
  logic [8:0] strap_accept;
  logic [2:0][2:0] member_reset;
  logic [2:0] pause_reset;
  logic [2:0] wr_c1;
  logic [2:0] wr_c2;
  logic [2:0] rd_c1;
  logic [2:0] rd_c2;
  logic [7:0] rd_mux;

  assign strap_pins = {strap_backpressure_on, strap_p2_force_pause, strap_p1_force_pause,
                       strap_p3_member_p1, strap_p3_member_p2, strap_p2_member_p1,
                       strap_p2_member_p3, strap_p1_member_p2, strap_p1_member_p3};

  // strap synchroniser, runs through reset
  always_ff @(posedge clock)
  begin
    strap_s1 <= strap_pins;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // accept a strap change once stages two and three agree
  assign strap_accept = (strap_s3 & ~(strap_s2 ^ strap_s3))
    | (strap_stable & (strap_s2 ^ strap_s3));

  always_ff @(posedge clock)
  begin
    strap_stable <= strap_accept;
  end

  // reset images use the accepted value, so a four-edge reset is enough
  assign member_reset[0] = {strap_accept[0], strap_accept[1], 1'b1}; // RQ8
  assign member_reset[1] = {strap_accept[2], 1'b1, strap_accept[3]}; // RQ8
  assign member_reset[2] = {1'b1, strap_accept[4], strap_accept[5]}; // RQ8
  assign pause_reset = {1'b0, strap_accept[7], strap_accept[6]}; // RQ12

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      assign wr_c1[p] = reg_req.wr && (reg_req.addr == CTRL1_OFF[p]); // RQ1
      assign wr_c2[p] = reg_req.wr && (reg_req.addr == CTRL2_OFF[p]); // RQ1
      assign rd_c1[p] = reg_req.addr == CTRL1_OFF[p];
      assign rd_c2[p] = reg_req.addr == CTRL2_OFF[p];

      // first control register
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          cfg1[p] <= {C1_UPPER_RESET, member_reset[p]}; // RQ2 RQ3 RQ4 RQ5 RQ9 RQ22
        end
        else if (wr_c1[p])
        begin
          cfg1[p] <= reg_req.wdata; // RQ6 RQ21
        end
      end

      // second control register, top bit held at zero
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          cfg2[p] <= {C2_UPPER_RESET, pause_reset[p], strap_accept[8], // RQ14 RQ22
            C2_LOWER_RESET}; // RQ12 RQ15 RQ16
        end
        else if (wr_c2[p])
        begin
          cfg2[p] <= {1'b0, reg_req.wdata[6:0]}; // RQ18 RQ21
        end
      end

      assign fwd_allow[p] = fwd_req[p] & cfg1[p].member; // RQ7
      assign port_default_vlan_id[p] = port_default_tag[p][TAG_VID_MSB:0]; // RQ19 RQ20
      assign default_prio[p] = port_default_tag[p][TAG_PRIO_MSB:TAG_PRIO_LSB]; // RQ20
      assign default_cfi[p] = port_default_tag[p][TAG_CFI]; // RQ20
      assign ingress_drop[p] = pkt_check[p]
        && ((cfg2[p].ingress_filter && !vlan_entry_member[p][p]) // RQ10
        || (cfg2[p].drop_non_default && (pkt_vid[p] != port_default_vlan_id[p]))); // RQ11
      assign learn_en[p] = !cfg2[p].learn_off; // RQ17
    end
  endgenerate

  // forced pause on ports 1 and 2, global bit on port 3
  assign pause_en[0] = cfg2[0].force_pause || an_pause[0]; // RQ12
  assign pause_en[1] = cfg2[1].force_pause || an_pause[1]; // RQ12
  assign pause_en[2] = global_pause_p3; // RQ13

  // read data select
  always_comb
  begin
    rd_mux = READ_UNMAPPED;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      rd_mux = rd_mux | ({8{rd_c1[i]}} & cfg1[i]) | ({8{rd_c2[i]}} & cfg2[i]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata <= READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
      begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_WR_CTRL1: assert property ( // RQ1
    reg_req.wr && reg_req.addr == 8'h21 |=> cfg1[1] == $past(reg_req.wdata))
    else $error("port 2 first register write not stored");

  AST_CTRL2_RESERVED: assert property ( // RQ18
    reg_req.wr && reg_req.addr == 8'h32 |=> !cfg2[2].reserved
      && cfg2[2][6:0] == $past(reg_req.wdata[6:0]))
    else $error("port 3 second register write wrong");

  AST_RESET_VALUES: assert property ( // RQ8
    $fell(rst) |-> cfg1[0].member[0] && cfg1[1].member[1] && cfg1[2].member[2]
      && cfg1[0][7:3] == 5'h00)
    else $error("first register reset value wrong");

  AST_RESET_ENABLES: assert property ( // RQ15
    $fell(rst) |-> cfg2[0].tx_enable && cfg2[1].rx_enable && !cfg2[2].learn_off
      && !cfg2[0].ingress_filter)
    else $error("second register reset value wrong");

  AST_FWD_BLOCK: assert property ( // RQ7
    !cfg1[0].member[2] |-> !fwd_allow[0][2])
    else $error("forward to excluded port");

  AST_DROP_FILTER: assert property ( // RQ10
    pkt_check[1] && cfg2[1].ingress_filter && !vlan_entry_member[1][1] |-> ingress_drop[1])
    else $error("ingress filter miss");

  AST_DROP_VID: assert property ( // RQ11
    pkt_check[0] && !cfg2[0].ingress_filter && ingress_drop[0]
      |-> cfg2[0].drop_non_default && pkt_vid[0] != port_default_tag[0][11:0])
    else $error("wrong vid drop");

  AST_PAUSE_P3: assert property ( // RQ13
    cfg2[2].force_pause && !global_pause_p3 |-> !pause_en[2])
    else $error("port 3 pause follows local bit");

  AST_LEARN: assert property ( // RQ17
    reg_req.wr && reg_req.addr == 8'h12 && reg_req.wdata[0] |=> !learn_en[0])
    else $error("learning not stopped");

  AST_STRAP_HOLD: assert property ( // RQ22
    $fell(rst) ##0 !reg_req.wr [*2] |-> $stable(cfg2[0].backpressure))
    else $error("strap bit moved after reset");

  AST_READ: assert property ( // RQ1
    reg_req.rd && reg_req.addr == 8'h31 && !reg_req.wr
      |=> reg_rvalid && reg_rdata == $past(cfg1[2]))
    else $error("read data wrong");

  AST_RVALID_PULSE: assert property ( // RQ1
    !reg_req.rd |=> !reg_rvalid)
    else $error("read valid without a read");

  AST_UNMAPPED_READ: assert property ( // RQ1
    reg_req.rd && reg_req.addr == 8'h13 |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_WR_MEMBER_P1: assert property ( // RQ6
    reg_req.wr && reg_req.addr == 8'h11 |=> cfg1[0].member == $past(reg_req.wdata[2:0]))
    else $error("port 1 membership write not stored");

  AST_WR_ENABLES_P2: assert property ( // RQ15
    reg_req.wr && reg_req.addr == 8'h22 |=> cfg2[1].tx_enable == $past(reg_req.wdata[2])
      && cfg2[1].rx_enable == $past(reg_req.wdata[1]))
    else $error("port 2 enable write not stored");

  AST_HOLD_CTRL1_P3: assert property ( // RQ21
    !(reg_req.wr && reg_req.addr == 8'h31) |=> $stable(cfg1[2]))
    else $error("port 3 first register changed without a write");

  AST_HOLD_CTRL2_P1: assert property ( // RQ21
    !(reg_req.wr && reg_req.addr == 8'h12) |=> $stable(cfg2[0]))
    else $error("port 1 second register changed without a write");

  AST_RESET_MIRROR: assert property ( // RQ2
    $fell(rst) |-> cfg1[0][7:3] == 5'h00 && cfg1[1][7:3] == 5'h00 && cfg1[2][7:3] == 5'h00)
    else $error("mirror or tag bits not clear after reset");

  AST_RESET_LOWER: assert property ( // RQ16
    $fell(rst) |-> cfg2[0][2:0] == 3'h6 && cfg2[1][2:0] == 3'h6 && cfg2[2][2:0] == 3'h6)
    else $error("enable or learning bits wrong after reset");

  AST_RESET_FILTERS: assert property ( // RQ10
    $fell(rst) |-> cfg2[0][7:5] == 3'h0 && cfg2[1][7:5] == 3'h0 && cfg2[2][7:5] == 3'h0)
    else $error("filter bits not clear after reset");

  AST_RESET_P3_PAUSE: assert property ( // RQ12
    $fell(rst) |-> !cfg2[2].force_pause)
    else $error("port 3 forced pause set after reset");

  AST_PAUSE_FORCE: assert property ( // RQ12
    cfg2[0].force_pause |-> pause_en[0])
    else $error("forced pause not applied");

  AST_PAUSE_AN: assert property ( // RQ12
    !cfg2[1].force_pause |-> pause_en[1] == an_pause[1])
    else $error("pause does not follow negotiation");

  AST_PAUSE_GLOBAL: assert property ( // RQ13
    global_pause_p3 |-> pause_en[2])
    else $error("port 3 pause ignores global bit");

  AST_FWD_MASK: assert property ( // RQ7
    (fwd_allow[2] & ~cfg1[2].member) == 3'h0)
    else $error("port 3 forwards outside its mask");

  AST_FWD_PASS: assert property ( // RQ7
    fwd_req[1][0] && cfg1[1].member[0] |-> fwd_allow[1][0])
    else $error("member port blocked");

  AST_LEARN_P3: assert property ( // RQ17
    cfg2[2].learn_off |-> !learn_en[2])
    else $error("port 3 learning not stopped");

  AST_DEFAULT_TAG: assert property ( // RQ20
    default_prio[1] == port_default_tag[1][15:13] && default_cfi[1] == port_default_tag[1][12])
    else $error("default tag fields wrong");

  AST_DROP_QUIET: assert property ( // RQ10
    !pkt_check[2] |-> !ingress_drop[2])
    else $error("drop without a check");

  COV_WRITE_MIRROR: cover property (reg_req.wr && reg_req.addr == 8'h11 && reg_req.wdata[7]);
  COV_PAUSE_P3: cover property (global_pause_p3 && cfg2[2].force_pause && pause_en[2]);
  COV_DROP: cover property (ingress_drop[2]);
  COV_UNMAPPED_READ: cover property (reg_req.rd && reg_req.addr == 8'h13);

endmodule

/* File: verif/spc_port_ctrl_regs_tb.sv */
`timescale 1ns/1ns
module spc_port_ctrl_regs_tb;
  import spc_pkg::*;
  // reset images for strap pattern 9'h159
  localparam logic [7:0] RST1 [3] = '{8'h05, 8'h03, 8'h06};
  localparam logic [7:0] RST2 [3] = '{8'h1E, 8'h0E, 8'h0E};
  logic clock, rst, global_pause_p3, reg_rvalid;
  spc_reg_req_t reg_req;
  logic [7:0] reg_rdata, v;
  logic [15:0] t;
  logic [8:0] st;
  logic [2:0][2:0] fwd_req, vlan_entry_member, fwd_allow, default_prio;
  logic [2:0] pkt_check, an_pause, ingress_drop, pause_en, learn_en, default_cfi;
  logic [2:0][11:0] pkt_vid, port_default_vlan_id;
  logic [2:0][15:0] port_default_tag;
  spc_ctrl1_t [2:0] cfg1;
  spc_ctrl2_t [2:0] cfg2;
  int n_fail, checks_done;

  spc_port_ctrl_regs DUT (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .strap_p1_member_p3(st[0]), .strap_p1_member_p2(st[1]),
    .strap_p2_member_p3(st[2]), .strap_p2_member_p1(st[3]), .strap_p3_member_p2(st[4]),
    .strap_p3_member_p1(st[5]), .strap_p1_force_pause(st[6]), .strap_p2_force_pause(st[7]),
    .strap_backpressure_on(st[8]), .fwd_req(fwd_req), .pkt_check(pkt_check),
    .pkt_vid(pkt_vid), .vlan_entry_member(vlan_entry_member),
    .port_default_tag(port_default_tag), .an_pause(an_pause),
    .global_pause_p3(global_pause_p3), .cfg1(cfg1), .cfg2(cfg2), .fwd_allow(fwd_allow),
    .ingress_drop(ingress_drop), .pause_en(pause_en), .learn_en(learn_en),
    .port_default_vlan_id(port_default_vlan_id), .default_prio(default_prio),
    .default_cfi(default_cfi));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge clock);
    #1 reg_req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    #1 reg_req = '0;
    chk("reg_rvalid", 16'h0001, 16'(reg_rvalid));
    chk("reg_rdata", 16'(e), 16'(reg_rdata));
  endtask

  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clock);
    n_fail++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    reg_req = '0;
    st = 9'h159;
    fwd_req = '0;
    pkt_check = '0;
    pkt_vid = '0;
    vlan_entry_member = '0;
    port_default_tag = '0;
    an_pause = '0;
    global_pause_p3 = 1'b0;
    repeat (RESET_HOLD_CYCLES) @(posedge clock);
    #1 rst = 1'b0;
    st = ~st;
    // reset images, straps changed after release
    for (int p = 0; p < 3; p++)
    begin
      rd(CTRL1_OFF[p], RST1[p]);
      rd(CTRL2_OFF[p], RST2[p]);
    end
    // unmapped places
    wr(8'h10, 8'hFF);
    rd(8'h13, READ_UNMAPPED);
    rd(CTRL1_OFF[0], RST1[0]);
    // write and read back every register
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 3; k++)
      begin
        v = (k == 0) ? 8'hFF : ((k == 1) ? 8'h00 : 8'hA5);
        wr(CTRL1_OFF[p], v);
        chk("cfg1", 16'(v), 16'(cfg1[p]));
        rd(CTRL1_OFF[p], v);
        wr(CTRL2_OFF[p], v);
        chk("cfg2", 16'(v & 8'h7F), 16'(cfg2[p]));
        rd(CTRL2_OFF[p], v & 8'h7F);
      end
    // membership mask gates forwarding
    fwd_req = '1;
    for (int p = 0; p < 3; p++)
      for (int m = 0; m < 8; m++)
      begin
        wr(CTRL1_OFF[p], 8'(m));
        chk("fwd_allow", 16'(m), 16'(fwd_allow[p]));
      end
    // ingress checks and default tag fields
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 32; k++)
      begin
        wr(CTRL2_OFF[p], {1'b0, k[0], k[1], 5'h06});
        t = 16'hB5A3 ^ 16'(k << 12);
        port_default_tag[p] = t;
        vlan_entry_member[p] = k[2] ? 3'h7 : ~(3'(1 << p));
        pkt_vid[p] = k[3] ? 12'h5A3 : 12'h5A2;
        pkt_check[p] = k[4];
        #1 chk("ingress_drop", 16'(k[4] & ((k[0] & ~k[2]) | (k[1] & ~k[3]))),
          16'(ingress_drop[p]));
        chk("default_prio", 16'(t[15:13]), 16'(default_prio[p]));
        chk("default_cfi", 16'(t[12]), 16'(default_cfi[p]));
        chk("default_vid", 16'(t[11:0]), 16'(port_default_vlan_id[p]));
      end
    // flow control and learning
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 4; k++)
      begin
        wr(CTRL2_OFF[p], {3'h0, k[0], 3'h3, k[0]});
        an_pause = {3{k[1]}};
        global_pause_p3 = !k[1];
        #1 chk("pause_en", 16'(p == 2 ? !k[1] : (k[0] | k[1])), 16'(pause_en[p]));
        chk("learn_en", 16'(!k[0]), 16'(learn_en[p]));
      end
    finish_test();
  end
endmodule
